// *** mgw_pkg.sv ***
// Purpose: shared constants for the medium, pin and wake control bank
// Assumes: AXI4-Lite slave, 32-bit data, index-based register map
// Notes: byte address of a register is four times its index
package mgw_pkg;
  // Register indices as printed; byte address is index * 4
  localparam logic [7:0] IDX_MEDIUM_RB = 8'h1A;
  localparam logic [7:0] IDX_MEDIUM_SET = 8'h1B;
  localparam logic [7:0] IDX_MON_RB = 8'h1C;
  localparam logic [7:0] IDX_MON_SET = 8'h1D;
  localparam logic [7:0] IDX_PIN_RB = 8'h1E;
  localparam logic [7:0] IDX_PIN_CTRL = 8'h1F;
  localparam logic [7:0] IDX_SOFT_RST = 8'h20;
  // Added register for wake and suspend control and status
  localparam logic [7:0] IDX_WAKE_CTRL = 8'h21;
  // Medium settings field positions
  localparam int MS_GM = 0;
  localparam int MS_FD = 1;
  localparam int MS_AC = 2;
  localparam int MS_TX_CLOCK_OUT_ENABLE = 3;
  localparam int MS_RFC = 4;
  localparam int MS_TFC = 5;
  localparam int MS_JFE = 6;
  localparam int MS_PF = 7;
  localparam int MS_RE = 8;
  localparam int MS_PS = 9;
  localparam int MS_SBP = 11;
  localparam int MS_SM = 12;
  localparam logic [15:0] MEDIUM_RESET = 16'h0276;
  localparam logic [15:0] MEDIUM_MASK = 16'h1BFF;
  // Monitor settings field positions
  localparam int MON_MOM = 0;
  localparam int MON_WAKE_ON_LINK_UP = 1;
  localparam int MON_WAKE_ON_MAGIC_PACKET = 2;
  localparam int MON_US = 4;
  localparam logic [7:0] MON_RESET = 8'h00;
  // Pin control field positions
  localparam int PIN_RSE = 7;
  localparam logic [7:0] PIN_RESET = 8'h00;
  // Soft reset field positions
  localparam int SR_RR = 0;
  localparam int SR_RT = 1;
  localparam int SR_PHY_RESET_FLOAT = 2;
  localparam int SR_PRL = 3;
  localparam int SR_BZ = 4;
  localparam logic [7:0] SOFT_RESET = 8'h4C;
  // Wake control field positions
  localparam int WK_SUSPEND = 0;
  localparam int WK_HOST_FEATURE = 1;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Speed encodings
  typedef enum logic [1:0] {
    MGW_SPD_10,
    MGW_SPD_100,
    MGW_SPD_1000
  } mgw_speed_t;
endpackage

// *** mgw_medium_ctrl.sv ***
// Purpose: medium, pin, PHY reset and remote wake control bank
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: strap-like inputs are not registered; they steer outputs combinationally
//
// Summary of operation
// (RQ1) Gigabit and port speed bits pick speed
// (RQ2) Full duplex bit chooses duplex mode
// (RQ3) Clock outputs only when enabled, per interface
// (RQ4) Pause receive and send enables in full
// (RQ5) Jumbo frames accepted only when enabled
// (RQ6) Pause identified by type, or address too
// (RQ7) Receive path runs only when enabled
// (RQ8) Half duplex backpressure continuous or intermittent
// (RQ9) Short backoff shortens collision retry time
// (RQ10) Software writes one to reserved bit
// (RQ11) Monitor mode checks but never stores
// (RQ12) Monitor readback shows USB speed, enables
// (RQ13) Pins driven when enable set, else float
// (RQ14) Pin enables and input levels readable
// (RQ15) Writing reload bit reloads EEPROM
// (RQ16) Held clear bits keep length errors cleared
// (RQ17) PHY reset floats unless float bit cleared
// (RQ18) Selected level drives PHY reset pin
// (RQ19) Force zero-length bulk IN packets
// (RQ20) Software writes 010 to top bits
// (RQ21) Wake returns to prior operating mode
// (RQ22) Self wake needs both permissions, one source
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module mgw_medium_ctrl
  import mgw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // MAC controls
  output mgw_pkg::mgw_speed_t link_speed,
  output logic full_duplex,
  output logic rx_pause_enable,
  output logic tx_pause_enable,
  output logic jumbo_enable,
  output logic pause_by_type_only,
  output logic rx_path_on,
  output logic monitor_mode,
  output logic rx_store_enable,
  input wire logic rx_buffer_full,
  output logic backpressure_continuous_active,
  output logic backpressure_intermittent_active,
  output logic short_backoff,
  // Clock outputs
  input wire logic rgmii_select,
  input wire logic gigabit_tx_clock_out_src,
  output logic gigabit_tx_clock_out,
  output logic tx_clock_out,
  // USB side
  input wire logic host_link_speed_hi,
  output logic reload_eeprom_pulse,
  output logic clear_bulk_in_len_err,
  output logic clear_bulk_out_len_err,
  output logic force_zero_length_in,
  // General purpose pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  // PHY reset pin
  input wire logic phy_reset_select_flag,
  input wire logic usb_reset_active,
  output logic phy_reset_pin_n_out,
  output logic phy_reset_pin_n_oe,
  // Remote wake
  input wire logic remote_wake_allowed_flag,
  input wire logic host_resume_seen,
  input wire logic magic_packet_seen,
  input wire logic link_up_primary,
  input wire logic link_up_secondary,
  input wire logic external_wake_pin_n,
  output logic suspended,
  output logic remote_wake_request
);
  import mgw_pkg::*;

  // Register state
  logic [15:0] medium_q;
  logic [2:0] mon_q;
  logic [6:0] pin_q;
  logic [4:0] srst_q;
  logic host_feature_q;
  logic rse_q;
  logic susp_q;
  logic wake_q;
  logic ext_prev_q;
  logic link_prev_q;
  // Bus channel state
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q, rresp_q;

  // Word index of a byte address; low bits ignored
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction

  // Index within the mapped set
  function automatic logic mapped(input logic [7:0] i, input logic [31:0] a);
    mapped = (a[31:10] == 22'h0) && (i >= IDX_MEDIUM_RB) && (i <= IDX_WAKE_CTRL);
  endfunction

  // Write decode
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire wr_lo = wstrb_q[0];
  wire wr_hi = wstrb_q[1];
  wire wr_ok = mapped(aw_idx_q, {22'h0, aw_idx_q, 2'b00});
  wire wr_med = do_write && (aw_idx_q == IDX_MEDIUM_SET);
  wire wr_mon = do_write && (aw_idx_q == IDX_MON_SET) && wr_lo;
  wire wr_pin = do_write && (aw_idx_q == IDX_PIN_CTRL) && wr_lo;
  wire wr_srst = do_write && (aw_idx_q == IDX_SOFT_RST) && wr_lo;
  wire wr_wake = do_write && (aw_idx_q == IDX_WAKE_CTRL) && wr_lo;

  // Medium merged with byte lanes; undefined bits stay zero
  wire [15:0] med_new = {wr_hi ? wdata_q[15:8] : medium_q[15:8],
                         wr_lo ? wdata_q[7:0] : medium_q[7:0]} & MEDIUM_MASK;

  // Read decode
  wire [7:0] rd_idx = word_idx(s_axi_araddr);
  wire rd_ok = mapped(rd_idx, s_axi_araddr);
  wire [7:0] pin_status = {2'b00, pin_in[2], pin_q[4], pin_in[1], pin_q[2],
                           pin_in[0], pin_q[0]}; // RQ14
  wire [7:0] mon_status = {3'b000, host_link_speed_hi, 1'b0, mon_q}; // RQ12
  wire [31:0] rd_word =
    (rd_idx == IDX_MEDIUM_RB) ? {16'h0, medium_q} :
    (rd_idx == IDX_MON_RB) ? {24'h0, mon_status} :
    (rd_idx == IDX_PIN_RB) ? {24'h0, pin_status} :
    (rd_idx == IDX_WAKE_CTRL) ? {28'h0, wake_q, susp_q, host_feature_q, susp_q} :
    32'h0;

  // Channel handshakes: ready while the slot is empty
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write address and data captured in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_idx_q <= (s_axi_awaddr[31:10] == 22'h0) ? word_idx(s_axi_awaddr) : 8'hFF;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response; read-only or unmapped slots answer SLVERR
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ok && aw_idx_q != IDX_MEDIUM_RB && aw_idx_q != IDX_MON_RB
                    && aw_idx_q != IDX_PIN_RB) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data registered one cycle after address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= AXI_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_ok ? rd_word : 32'h0;
        rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Settings registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      medium_q <= MEDIUM_RESET;
      mon_q <= MON_RESET[2:0];
      pin_q <= PIN_RESET[6:0];
      srst_q <= SOFT_RESET[4:0];
      host_feature_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_med) medium_q <= med_new; // RQ10 reserved bit stored as written
      if (wr_mon) mon_q <= wdata_q[2:0];
      if (wr_pin) pin_q <= {wdata_q[5], wdata_q[5:0]} & 7'h3F;
      // Upper 010 pattern is the writer's duty and is not checked
      if (wr_srst) srst_q <= wdata_q[4:0]; // RQ20
      if (wr_wake) host_feature_q <= wdata_q[WK_HOST_FEATURE];
    end
  end

  // Reload request is a one-cycle pulse per write of one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rse_q <= 1'b0;
    else if (clk_en) rse_q <= wr_pin && wdata_q[PIN_RSE]; // RQ15
  end
  assign reload_eeprom_pulse = rse_q;

  // Medium decode
  assign link_speed = medium_q[MS_GM] ? MGW_SPD_1000 :
                      (medium_q[MS_PS] ? MGW_SPD_100 : MGW_SPD_10); // RQ1
  assign full_duplex = medium_q[MS_FD]; // RQ2
  // Pause only meaningful in full duplex
  assign rx_pause_enable = medium_q[MS_RFC] && medium_q[MS_FD]; // RQ4
  assign tx_pause_enable = medium_q[MS_TFC] && medium_q[MS_FD]; // RQ4
  assign jumbo_enable = medium_q[MS_JFE] && medium_q[MS_GM]; // RQ5
  assign pause_by_type_only = medium_q[MS_PF]; // RQ6
  assign rx_path_on = medium_q[MS_RE]; // RQ7
  assign short_backoff = medium_q[MS_SM]; // RQ9
  // Backpressure style in half duplex with a full receive buffer
  wire bp_cond = medium_q[MS_TFC] && !medium_q[MS_FD] && rx_buffer_full;
  assign backpressure_continuous_active = bp_cond && medium_q[MS_SBP]; // RQ8
  assign backpressure_intermittent_active = bp_cond && !medium_q[MS_SBP]; // RQ8
  assign monitor_mode = mon_q[MON_MOM];
  // Monitor mode checks frames but keeps them out of buffer memory
  assign rx_store_enable = medium_q[MS_RE] && !mon_q[MON_MOM]; // RQ11

  // Clock outputs gated; either or neither toggles
  assign gigabit_tx_clock_out = medium_q[MS_TX_CLOCK_OUT_ENABLE] && !rgmii_select && gigabit_tx_clock_out_src; // RQ3
  assign tx_clock_out = medium_q[MS_TX_CLOCK_OUT_ENABLE] && rgmii_select && gigabit_tx_clock_out_src; // RQ3

  // General purpose pins
  assign pin_oe = {pin_q[4], pin_q[2], pin_q[0]}; // RQ13
  assign pin_out = {pin_q[5], pin_q[3], pin_q[1]}; // RQ13

  // Soft reset controls
  assign clear_bulk_in_len_err = srst_q[SR_RR]; // RQ16
  assign clear_bulk_out_len_err = srst_q[SR_RT]; // RQ16
  assign force_zero_length_in = srst_q[SR_BZ]; // RQ19
  // PHY reset: float, software level, or follow USB reset (low active)
  assign phy_reset_pin_n_oe = !srst_q[SR_PHY_RESET_FLOAT]; // RQ17
  assign phy_reset_pin_n_out = phy_reset_select_flag ? srst_q[SR_PRL] // RQ18
                                                     : !usb_reset_active; // RQ17

  // Remote wake decision; one source suffices once both permissions hold
  wire wake_allowed = remote_wake_allowed_flag && host_feature_q; // RQ22
  wire ext_fall = ext_prev_q && !external_wake_pin_n;
  wire link_rise = (link_up_primary || link_up_secondary) && !link_prev_q;
  wire self_wake = wake_allowed && ((mon_q[MON_WAKE_ON_MAGIC_PACKET] && magic_packet_seen) ||
                   (mon_q[MON_WAKE_ON_LINK_UP] && link_rise) || ext_fall); // RQ22

  // Suspend state; settings are untouched so wake resumes prior mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      susp_q <= 1'b0;
      wake_q <= 1'b0;
      ext_prev_q <= 1'b1;
      link_prev_q <= 1'b0;
    end else if (clk_en) begin
      ext_prev_q <= external_wake_pin_n;
      link_prev_q <= link_up_primary || link_up_secondary;
      wake_q <= susp_q && self_wake;
      if (susp_q && (host_resume_seen || self_wake)) susp_q <= 1'b0; // RQ21
      else if (wr_wake) susp_q <= wdata_q[WK_SUSPEND];
    end
  end
  assign suspended = susp_q;
  assign remote_wake_request = wake_q;

  // Checks
  speed_map_a: assert property (@(posedge clk) disable iff (!nrst)
    (medium_q[MS_GM] == 1'b0 && medium_q[MS_PS] == 1'b0) |-> link_speed == MGW_SPD_10)
    else $error("speed decode wrong"); // RQ1
  pin_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && wr_pin) |=> pin_oe[0] == $past(wdata_q[0]))
    else $error("pin enable not taken"); // RQ13
  phy_float_a: assert property (@(posedge clk) disable iff (!nrst)
    srst_q[SR_PHY_RESET_FLOAT] |-> !phy_reset_pin_n_oe)
    else $error("phy reset driven while floating"); // RQ17
  phy_level_a: assert property (@(posedge clk) disable iff (!nrst)
    (!srst_q[SR_PHY_RESET_FLOAT] && phy_reset_select_flag) |-> phy_reset_pin_n_out == srst_q[SR_PRL])
    else $error("phy reset level wrong"); // RQ18
  mon_store_a: assert property (@(posedge clk) disable iff (!nrst)
    mon_q[MON_MOM] |-> !rx_store_enable)
    else $error("stored in monitor mode"); // RQ11
  clk_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    !medium_q[MS_TX_CLOCK_OUT_ENABLE] |-> !gigabit_tx_clock_out && !tx_clock_out)
    else $error("clock out while disabled"); // RQ3
  wake_perm_a: assert property (@(posedge clk) disable iff (!nrst)
    remote_wake_request |-> $past(remote_wake_allowed_flag) && $past(host_feature_q))
    else $error("wake without permission"); // RQ22
  resume_a: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && susp_q && host_resume_seen) |=> !susp_q)
    else $error("host resume ignored"); // RQ21
  reload_a: assert property (@(posedge clk) disable iff (!nrst)
    reload_eeprom_pulse |=> !reload_eeprom_pulse || $past(wr_pin))
    else $error("reload pulse stuck"); // RQ15
endmodule
`default_nettype wire

// *** mgw_far_side_model.sv ***
// Purpose: far side of the bank: pin loads, PHY reset net, USB host speed
// Assumes: pins 0 and 1 have pull-ups, pin 2 is held low by an outside part
// Notes: purely combinational; contention is not modelled
`timescale 1ns/10ps
`default_nettype none
module mgw_far_side_model #(
  parameter logic HOST_HS = 1'b1
) (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic phy_reset_pin_n_out,
  input wire logic phy_reset_pin_n_oe,
  output logic [2:0] pin_in,
  output logic host_link_speed_hi,
  output logic phy_level
);
  // Undriven pins fall back to the board level, never the last driven value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & 3'b011);
  // Pull-up on the PHY reset net keeps the PHY out of reset when floated
  assign phy_level = phy_reset_pin_n_oe ? phy_reset_pin_n_out : 1'b1;
  // Host negotiated high speed
  assign host_link_speed_hi = HOST_HS;
endmodule
`default_nettype wire

// *** mgw_medium_ctrl_bench.sv ***
// Purpose: self-checking bench for the medium, pin and wake control bank
// Assumes: AXI4-Lite master, one transfer of each kind at a time
// Notes: byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module mgw_medium_ctrl_bench;
  import mgw_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic clk_en = 1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mgw_speed_t link_speed;
  logic full_duplex, rx_pause_enable, tx_pause_enable, jumbo_enable, pause_by_type_only;
  logic rx_path_on, monitor_mode, rx_store_enable, short_backoff, suspended;
  logic backpressure_continuous_active, backpressure_intermittent_active;
  logic gigabit_tx_clock_out, tx_clock_out, host_link_speed_hi, reload_eeprom_pulse;
  logic clear_bulk_in_len_err, clear_bulk_out_len_err, force_zero_length_in;
  logic [2:0] pin_in, pin_out, pin_oe;
  logic phy_reset_pin_n_out, phy_reset_pin_n_oe, phy_level, remote_wake_request;
  logic rx_buffer_full = 0, rgmii_select = 0, gigabit_tx_clock_out_src = 1, phy_reset_select_flag = 0;
  logic usb_reset_active = 0, remote_wake_allowed_flag = 0, host_resume_seen = 0;
  logic magic_packet_seen = 0, link_up_primary = 0, link_up_secondary = 0;
  logic external_wake_pin_n = 1;
  int error_cnt = 0, total_checks = 0, cyc = 0, reload_cnt = 0, wake_cnt = 0;

  mgw_medium_ctrl DUT (.clk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_speed, .full_duplex,
    .rx_pause_enable, .tx_pause_enable, .jumbo_enable, .pause_by_type_only, .rx_path_on,
    .monitor_mode, .rx_store_enable, .rx_buffer_full, .backpressure_continuous_active,
    .backpressure_intermittent_active, .short_backoff, .rgmii_select, .gigabit_tx_clock_out_src,
    .gigabit_tx_clock_out, .tx_clock_out, .host_link_speed_hi, .reload_eeprom_pulse,
    .clear_bulk_in_len_err, .clear_bulk_out_len_err, .force_zero_length_in, .pin_in,
    .pin_out, .pin_oe, .phy_reset_select_flag, .usb_reset_active, .phy_reset_pin_n_out,
    .phy_reset_pin_n_oe, .remote_wake_allowed_flag, .host_resume_seen, .magic_packet_seen,
    .link_up_primary, .link_up_secondary, .external_wake_pin_n, .suspended,
    .remote_wake_request);

  // Far side: pin loads, PHY reset pull-up, host speed
  mgw_far_side_model far (.pin_out, .pin_oe, .phy_reset_pin_n_out, .phy_reset_pin_n_oe,
    .pin_in, .host_link_speed_hi, .phy_level);

  // 50 MHz clock
  always #10 clk = ~clk;

  // Pulse counters and hang guard; pulses last one cycle so count them here
  // Counted on the falling edge, where a pulse stands settled, so a check
  // made at the rising edge never races the count
  always @(negedge clk) begin
    cyc++;
    if (reload_eeprom_pulse === 1'b1) reload_cnt++;
    if (remote_wake_request === 1'b1) wake_cnt++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1;
        s_axi_awvalid <= 0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask

  // Read with expected data and response
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  // Suspend, fire one wake source, then see whether the device woke
  task automatic wake_try(input int sel, input logic allow, input logic exp_s);
    int c0;
    remote_wake_allowed_flag <= allow;
    axi_wr(32'h84, 32'h3, AXI_OKAY);
    chk(suspended, 1);
    c0 = wake_cnt;
    @(posedge clk);
    case (sel)
      0: magic_packet_seen <= 1;
      1: external_wake_pin_n <= 0;
      2: link_up_secondary <= 1;
      default: host_resume_seen <= 1;
    endcase
    @(posedge clk);
    magic_packet_seen <= 0;
    external_wake_pin_n <= 1;
    host_resume_seen <= 0;
    repeat (4) @(posedge clk);
    link_up_secondary <= 0;
    chk(suspended, exp_s);
    // Host resume is not a self wake, so no request count is expected there
    if (sel < 3) chk(wake_cnt - c0, 32'(!exp_s));
  endtask

  // Closing report
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge clk);
    nrst <= 1;
    axi_rd(32'h68, 32'h0276, AXI_OKAY);
    chk(link_speed, MGW_SPD_100);
    chk({full_duplex, rx_pause_enable, tx_pause_enable, jumbo_enable}, 4'hE);
    chk({rx_path_on, pause_by_type_only, short_backoff}, 0);
    chk({gigabit_tx_clock_out, tx_clock_out, pin_oe, phy_reset_pin_n_oe}, 0);
    axi_rd(32'h70, 32'h10, AXI_OKAY);
    // Every speed code, with the reserved bit kept at one
    for (int k = 0; k < 4; k++) begin
      d = 32'h74 | 32'(k[1]) | (32'(k[0]) << 9);
      axi_wr(32'h6C, d, AXI_OKAY);
      axi_rd(32'h68, d, AXI_OKAY);
      chk(link_speed, k[1] ? MGW_SPD_1000 : (k[0] ? MGW_SPD_100 : MGW_SPD_10));
    end
    rx_buffer_full <= 1;
    axi_wr(32'h6C, 32'h0824, AXI_OKAY);
    chk({backpressure_continuous_active, backpressure_intermittent_active}, 2'b10);
    chk({full_duplex, rx_pause_enable, tx_pause_enable}, 0);
    axi_wr(32'h6C, 32'h0024, AXI_OKAY);
    chk({backpressure_continuous_active, backpressure_intermittent_active}, 2'b01);
    axi_wr(32'h6C, 32'h11CF, AXI_OKAY);
    chk({link_speed, jumbo_enable, pause_by_type_only, rx_path_on, short_backoff}, 6'h2F);
    chk({gigabit_tx_clock_out, tx_clock_out}, 2'b10);
    rgmii_select <= 1;
    @(posedge clk);
    chk({gigabit_tx_clock_out, tx_clock_out}, 2'b01);
    axi_wr(32'h74, 32'h07, AXI_OKAY);
    chk({monitor_mode, rx_store_enable}, 2'b10);
    axi_rd(32'h70, 32'h17, AXI_OKAY);
    axi_rd(32'h6C, 32'h0, AXI_OKAY);
    axi_wr(32'h7C, 32'h8B, AXI_OKAY);
    chk(reload_cnt, 1);
    chk({pin_oe, pin_out}, 6'b001011);
    axi_rd(32'h78, 32'h0B, AXI_OKAY);
    axi_wr(32'h7C, 32'h15, AXI_OKAY);
    axi_rd(32'h78, 32'h15, AXI_OKAY);
    chk({reload_cnt[1:0], pin_in}, 5'b01000);
    phy_reset_select_flag <= 1;
    axi_wr(32'h80, 32'h53, AXI_OKAY);
    chk({clear_bulk_in_len_err, clear_bulk_out_len_err, force_zero_length_in}, 3'h7);
    chk({phy_reset_pin_n_oe, phy_level}, 2'b10);
    phy_reset_select_flag <= 0;
    usb_reset_active <= 1;
    @(posedge clk);
    chk(phy_level, 0);
    usb_reset_active <= 0;
    @(posedge clk);
    chk(phy_level, 1);
    axi_wr(32'h80, 32'h44, AXI_OKAY);
    chk({clear_bulk_in_len_err, clear_bulk_out_len_err, force_zero_length_in}, 0);
    chk(phy_reset_pin_n_oe, 0);
    axi_wr(32'h68, 32'h0, AXI_SLVERR);
    axi_rd(32'hFC, 32'h0, AXI_SLVERR);
    wake_try(0, 1, 0);
    wake_try(0, 0, 1);
    wake_try(3, 0, 0);
    wake_try(1, 1, 0);
    wake_try(2, 1, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
